// file: pkg/caf_defines.vh
// constants for the can acceptance filter: register map, field layout, reset values
`ifndef CAF_DEFINES_VH
`define CAF_DEFINES_VH

// apb address width and register byte offsets
`define CAF_ADDR_W        8
`define CAF_OFF_FEN       8'h00
`define CAF_OFF_PTR1      8'h04
`define CAF_OFF_PTR2      8'h08
`define CAF_OFF_PTR3      8'h0c
`define CAF_OFF_PTR4      8'h10
`define CAF_OFF_MSEL_LO   8'h14
`define CAF_OFF_MSEL_HI   8'h18
`define CAF_OFF_FULL      8'h20
`define CAF_OFF_OVF       8'h24
`define CAF_OFF_IST       8'h28
`define CAF_OFF_IMASK     8'h2c

// indexed regions: filter std ids 0x40-0x7c, filter ext ids 0x80-0xbc
`define CAF_RGN_FSID      2'b01
`define CAF_RGN_FEID      2'b10
// mask std ids 0xc0-0xc8, mask ext ids 0xd0-0xd8
`define CAF_RGN_MSID      4'hc
`define CAF_RGN_MEID      4'hd
`define CAF_NUM_MASKS     2'b11

// standard identifier register layout
`define CAF_SID_IMPL      16'hffeb
`define CAF_SID_HI        15
`define CAF_SID_LO        5
`define CAF_TYPE_BIT      3
`define CAF_EID_HI_HI     1
`define CAF_EID_HI_LO     0

// field values
`define CAF_PTR_FIFO      4'hf
`define CAF_MSEL_RSVD     2'b11
`define CAF_MSEL_M0       2'b00
`define CAF_MSEL_M1       2'b01
`define CAF_MSEL_M2       2'b10

// reset values
`define CAF_FEN_RST       16'hffff
`define CAF_ZERO16        16'h0000
`define CAF_ZERO32        32'h0000_0000

// interrupt status bit positions
`define CAF_IRQ_W         4
`define CAF_IRQ_BUF       0
`define CAF_IRQ_FIFO      1
`define CAF_IRQ_OVF       2
`define CAF_IRQ_MISS      3

// counts
`define CAF_NUM_FILT      16
`define CAF_NUM_BUF       15

`endif

// file: rtl/caf_accept_filter.v
// can receive acceptance filter with apb register file and routing of accepted messages
// How it works
// R1: pointer code 1111 routes to receive fifo, 0000-1110 to that buffer number.
// R2: fourth pointer register holds filters 15 down to 12, four bits each.
// R3: filter standard id in bits 15-5; compared bits must equal.
// R4: filter extended bits 17-16 in std reg bits 1-0, 15-0 in ext reg.
// R5: filter bit 3 picks extended or standard frames when type match enabled.
// R6: mask source 00,01,10 pick masks 0,1,2; 11 reserved.
// R7: mask select low holds filters 7..0, high holds 15..8, two bits each.
// R8: mask bits 15-5 enable standard id bit comparison; 0 means don't care.
// R9: mask bits 1-0 enable comparison of extended bits 17-16.
// R10: mask bit 3 set demands frame type equal to filter selection.
// R11: mask bit 3 clear accepts both types on their identifier bits.
// R12: bits 4 and 2 of filter and mask std registers read zero.
// R13: mask ext register enables extended bits 15-0 comparison.
// R14: sixteen bit enable vector gates filters; all set after reset.
// R15: store sets buffer full, storing to full sets overflow; writing 0 clears.
// R16: every enabled filter compared, hit routes to its pointer destination.
`timescale 1ns/1ps
`default_nettype none
`include "caf_defines.vh"

module caf_accept_filter (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire [31:0] prdata,
  output wire        pslverr,
  // received identifiers from the protocol engine
  input  wire        rx_valid,
  input  wire        rx_ext,
  input  wire [10:0] rx_std_id,
  input  wire [17:0] rx_ext_id,
  // routing result
  output wire        acc_valid,
  output wire        acc_to_fifo,
  output wire [3:0]  acc_dest,
  output wire [3:0]  acc_filter,
  output wire        acc_overflow,
  output wire        rej_valid,
  // buffer flags and interrupt
  output wire [14:0] rx_buffer_full_flags,
  output wire [14:0] rx_buffer_overflow_flags,
  output wire        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // storage

  reg  [15:0]  filter_enable_vector_reg;
  reg  [63:0]  dest_ptr_reg;
  reg  [31:0]  mask_select_reg;
  reg  [255:0] filter_std_id_reg;
  reg  [255:0] filter_ext_id_reg;
  reg  [47:0]  mask_std_id_reg;
  reg  [47:0]  mask_ext_id_reg;
  reg  [14:0]  full_reg;
  reg  [14:0]  ovf_reg;
  reg  [3:0]   irq_status_reg;
  reg  [3:0]   irq_mask_reg;
  reg  [31:0]  prdata_reg;
  reg          err_reg;
  reg          acc_valid_reg;
  reg          acc_to_fifo_reg;
  reg  [3:0]   acc_dest_reg;
  reg  [3:0]   acc_filter_reg;
  reg          acc_overflow_reg;
  reg          rej_valid_reg;

  reg  [31:0]  rd_next;
  reg          err_next;
  reg  [14:0]  full_next;
  reg  [14:0]  ovf_next;
  reg  [3:0]   irq_status_next;

  wire [15:0]  hits;
  wire         any_hit;
  wire [3:0]   win_filter;
  wire [3:0]   win_dest;
  wire         route_hit;
  wire         route_fifo;
  wire [14:0]  store_vec;
  wire [14:0]  ovf_set;
  wire [3:0]   irq_set;

  wire         setup_ph;
  wire         access_ph;
  wire         wr_en;
  wire         rd_en;
  wire [3:0]   fidx;
  wire [1:0]   midx;
  wire [1:0]   rgn2;
  wire [3:0]   rgn4;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_en     = access_ph & pwrite & ~err_reg;
  assign rd_en     = access_ph & ~pwrite & ~err_reg;
  assign fidx      = paddr[5:2];
  assign midx      = paddr[3:2];
  assign rgn2      = paddr[7:6];
  assign rgn4      = paddr[7:4];

  // zero wait states: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign prdata  = prdata_reg;
  assign pslverr = access_ph & err_reg;

  // read mux and address check; unused bits read zero
  always @*
  begin
    rd_next  = `CAF_ZERO32;
    err_next = 1'b0;
    if (rgn2 == `CAF_RGN_FSID)
      rd_next[15:0] = filter_std_id_reg[fidx*16 +: 16] & `CAF_SID_IMPL;  // R12
    else if (rgn2 == `CAF_RGN_FEID)
      rd_next[15:0] = filter_ext_id_reg[fidx*16 +: 16];
    else if (rgn4 == `CAF_RGN_MSID && midx != `CAF_NUM_MASKS)
      rd_next[15:0] = mask_std_id_reg[midx*16 +: 16] & `CAF_SID_IMPL;  // R12
    else if (rgn4 == `CAF_RGN_MEID && midx != `CAF_NUM_MASKS)
      rd_next[15:0] = mask_ext_id_reg[midx*16 +: 16];
    else
    begin
      case (paddr)
        `CAF_OFF_FEN:     rd_next[15:0] = filter_enable_vector_reg;
        `CAF_OFF_PTR1:    rd_next[15:0] = dest_ptr_reg[15:0];
        `CAF_OFF_PTR2:    rd_next[15:0] = dest_ptr_reg[31:16];
        `CAF_OFF_PTR3:    rd_next[15:0] = dest_ptr_reg[47:32];
        `CAF_OFF_PTR4:    rd_next[15:0] = dest_ptr_reg[63:48];
        `CAF_OFF_MSEL_LO: rd_next[15:0] = mask_select_reg[15:0];
        `CAF_OFF_MSEL_HI: rd_next[15:0] = mask_select_reg[31:16];
        `CAF_OFF_FULL:    rd_next[14:0] = full_reg;
        `CAF_OFF_OVF:     rd_next[14:0] = ovf_reg;
        `CAF_OFF_IST:     rd_next[3:0]  = irq_status_reg;
        `CAF_OFF_IMASK:   rd_next[3:0]  = irq_mask_reg;
        default:          err_next      = 1'b1;
      endcase
    end
  end

  // capture read data and error in the setup cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= `CAF_ZERO32;
      err_reg    <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_reg <= pwrite ? `CAF_ZERO32 : rd_next;
      err_reg    <= err_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  // plain software registers; ids reset to zero for determinism
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filter_enable_vector_reg <= `CAF_FEN_RST;  // R14
      dest_ptr_reg             <= 64'h0000_0000_0000_0000;
      mask_select_reg          <= `CAF_ZERO32;
      filter_std_id_reg        <= {16{`CAF_ZERO16}};
      filter_ext_id_reg        <= {16{`CAF_ZERO16}};
      mask_std_id_reg          <= {3{`CAF_ZERO16}};
      mask_ext_id_reg          <= {3{`CAF_ZERO16}};
      irq_mask_reg             <= 4'h0;
    end
    else if (wr_en)
    begin
      if (rgn2 == `CAF_RGN_FSID)
        filter_std_id_reg[fidx*16 +: 16] <= pwdata[15:0] & `CAF_SID_IMPL;  // R3 R4 R12
      else if (rgn2 == `CAF_RGN_FEID)
        filter_ext_id_reg[fidx*16 +: 16] <= pwdata[15:0];  // R4
      else if (rgn4 == `CAF_RGN_MSID)
        mask_std_id_reg[midx*16 +: 16] <= pwdata[15:0] & `CAF_SID_IMPL;  // R8 R9 R12
      else if (rgn4 == `CAF_RGN_MEID)
        mask_ext_id_reg[midx*16 +: 16] <= pwdata[15:0];  // R13
      else
      begin
        case (paddr)
          `CAF_OFF_FEN:     filter_enable_vector_reg <= pwdata[15:0];
          `CAF_OFF_PTR1:    dest_ptr_reg[15:0]       <= pwdata[15:0];
          `CAF_OFF_PTR2:    dest_ptr_reg[31:16]      <= pwdata[15:0];
          `CAF_OFF_PTR3:    dest_ptr_reg[47:32]      <= pwdata[15:0];
          `CAF_OFF_PTR4:    dest_ptr_reg[63:48]      <= pwdata[15:0];  // R2
          `CAF_OFF_MSEL_LO: mask_select_reg[15:0]    <= pwdata[15:0];  // R7
          `CAF_OFF_MSEL_HI: mask_select_reg[31:16]   <= pwdata[15:0];  // R7
          `CAF_OFF_IMASK:   irq_mask_reg             <= pwdata[3:0];
          default:          irq_mask_reg             <= irq_mask_reg;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // filter bank

  // one comparator per filter, each on its own two-bit mask source field
  genvar g;
  generate
    for (g = 0; g < `CAF_NUM_FILT; g = g + 1)
    begin : g_filt
      caf_filter_match u_match (
        .enable       (filter_enable_vector_reg[g]),
        .mask_source  (mask_select_reg[g*2 +: 2]),
        .filt_sid     (filter_std_id_reg[g*16 +: 16]),
        .filt_eid     (filter_ext_id_reg[g*16 +: 16]),
        .mask_sid_all (mask_std_id_reg),
        .mask_eid_all (mask_ext_id_reg),
        .msg_ext      (rx_ext),
        .msg_std_id   (rx_std_id),
        .msg_ext_id   (rx_ext_id),
        .hit          (hits[g])
      );
    end
  endgenerate

  // lowest filter number wins when several hit
  caf_route_select u_route (
    .hits       (hits),
    .dest_ptrs  (dest_ptr_reg),
    .any_hit    (any_hit),
    .win_filter (win_filter),
    .win_dest   (win_dest)
  );

  ////////////////////////////////////////////////////////////////////////////
  // routing and buffer flags

  assign route_hit  = rx_valid & any_hit;  // R16
  assign route_fifo = route_hit & (win_dest == `CAF_PTR_FIFO);  // R1

  // one store strobe per dedicated buffer
  generate
    for (g = 0; g < `CAF_NUM_BUF; g = g + 1)
    begin : g_buf
      assign store_vec[g] = route_hit & (win_dest == g);  // R1
      assign ovf_set[g]   = store_vec[g] & full_reg[g];  // R15
    end
  endgenerate

  // software clears by writing 0; a store in the same cycle still sets
  always @*
  begin
    full_next = full_reg;
    ovf_next  = ovf_reg;
    if (wr_en && paddr == `CAF_OFF_FULL)
      full_next = full_reg & pwdata[14:0];
    if (wr_en && paddr == `CAF_OFF_OVF)
      ovf_next = ovf_reg & pwdata[14:0];
    full_next = full_next | store_vec;  // R15
    ovf_next  = ovf_next | ovf_set;  // R15
  end

  // registered result, one cycle after the identifier is offered
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      full_reg         <= 15'h0000;
      ovf_reg          <= 15'h0000;
      acc_valid_reg    <= 1'b0;
      acc_to_fifo_reg  <= 1'b0;
      acc_dest_reg     <= 4'h0;
      acc_filter_reg   <= 4'h0;
      acc_overflow_reg <= 1'b0;
      rej_valid_reg    <= 1'b0;
    end
    else
    begin
      full_reg         <= full_next;
      ovf_reg          <= ovf_next;
      acc_valid_reg    <= route_hit;
      acc_to_fifo_reg  <= route_fifo;
      acc_overflow_reg <= |ovf_set;
      rej_valid_reg    <= rx_valid & ~any_hit;
      if (route_hit)
      begin
        acc_dest_reg   <= win_dest;  // R1 R16
        acc_filter_reg <= win_filter;
      end
    end
  end

  assign acc_valid                = acc_valid_reg;
  assign acc_to_fifo              = acc_to_fifo_reg;
  assign acc_dest                 = acc_dest_reg;
  assign acc_filter               = acc_filter_reg;
  assign acc_overflow             = acc_overflow_reg;
  assign rej_valid                = rej_valid_reg;
  assign rx_buffer_full_flags     = full_reg;
  assign rx_buffer_overflow_flags = ovf_reg;

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  assign irq_set[`CAF_IRQ_BUF]  = route_hit & ~route_fifo;
  assign irq_set[`CAF_IRQ_FIFO] = route_fifo;
  assign irq_set[`CAF_IRQ_OVF]  = |ovf_set;
  assign irq_set[`CAF_IRQ_MISS] = rx_valid & ~any_hit;

  // reading status clears it, but an event in that cycle survives
  always @*
  begin
    irq_status_next = irq_status_reg;
    if (rd_en && paddr == `CAF_OFF_IST)
      irq_status_next = 4'h0;
    irq_status_next = irq_status_next | irq_set;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status_reg <= 4'h0;
    else
      irq_status_reg <= irq_status_next;
  end

  // level output while any unmasked event is pending
  assign irq = |(irq_status_reg & irq_mask_reg);

endmodule // caf_accept_filter

`default_nettype wire

// file: rtl/caf_filter_match.v
// one acceptance filter compared against an incoming identifier through its selected mask
`timescale 1ns/1ps
`default_nettype none
`include "caf_defines.vh"

module caf_filter_match (
  // filter configuration
  input  wire        enable,
  input  wire [1:0]  mask_source,
  input  wire [15:0] filt_sid,
  input  wire [15:0] filt_eid,
  // the three masks
  input  wire [47:0] mask_sid_all,
  input  wire [47:0] mask_eid_all,
  // incoming message
  input  wire        msg_ext,
  input  wire [10:0] msg_std_id,
  input  wire [17:0] msg_ext_id,
  // result
  output wire        hit
);

  reg  [15:0] msk_sid;
  reg  [15:0] msk_eid;
  reg         src_ok;
  wire [10:0] std_ok;
  wire [17:0] ext_ok;
  wire [17:0] filt_ext;
  wire [17:0] msk_ext;
  wire        type_match_enable;
  wire        type_ok;

  // mask pick; the reserved code selects nothing, so such a filter never hits
  always @*
  begin
    msk_sid = `CAF_ZERO16;
    msk_eid = `CAF_ZERO16;
    src_ok  = 1'b1;
    case (mask_source)
      `CAF_MSEL_M0:
      begin
        msk_sid = mask_sid_all[15:0];
        msk_eid = mask_eid_all[15:0];
      end
      `CAF_MSEL_M1:
      begin
        msk_sid = mask_sid_all[31:16];
        msk_eid = mask_eid_all[31:16];
      end
      `CAF_MSEL_M2:
      begin
        msk_sid = mask_sid_all[47:32];
        msk_eid = mask_eid_all[47:32];
      end
      default:
        src_ok = 1'b0;  // R6
    endcase
  end

  // per-bit compare: equal or masked out
  assign std_ok   = ~(msg_std_id ^ filt_sid[`CAF_SID_HI:`CAF_SID_LO]) | ~msk_sid[`CAF_SID_HI:`CAF_SID_LO]; // R3 R8
  assign filt_ext = {filt_sid[`CAF_EID_HI_HI:`CAF_EID_HI_LO], filt_eid};
  assign msk_ext  = {msk_sid[`CAF_EID_HI_HI:`CAF_EID_HI_LO], msk_eid};
  assign ext_ok   = ~(msg_ext_id ^ filt_ext) | ~msk_ext;  // R4 R9 R13

  // frame type only checked when the mask asks for it
  assign type_match_enable = msk_sid[`CAF_TYPE_BIT];
  assign type_ok = ~type_match_enable | (msg_ext == filt_sid[`CAF_TYPE_BIT]);  // R5 R10

  // standard frames carry no extended bits, so those are skipped for them
  assign hit = enable & src_ok & type_ok & (&std_ok) & (~msg_ext | (&ext_ok));  // R11 R14

endmodule // caf_filter_match

`default_nettype wire

// file: rtl/caf_route_select.v
// picks the lowest numbered hitting filter and returns its destination pointer
`timescale 1ns/1ps
`default_nettype none
`include "caf_defines.vh"

module caf_route_select (
  // per filter hits and pointers
  input  wire [15:0] hits,
  input  wire [63:0] dest_ptrs,
  // winner
  output reg         any_hit,
  output reg  [3:0]  win_filter,
  output reg  [3:0]  win_dest
);

  integer i;

  // scan from the top so the lowest index is the last to assign
  always @*
  begin
    any_hit    = 1'b0;
    win_filter = 4'h0;
    win_dest   = 4'h0;
    for (i = `CAF_NUM_FILT - 1; i >= 0; i = i - 1)
    begin
      if (hits[i])
      begin
        any_hit    = 1'b1;
        win_filter = i[3:0];
        win_dest   = dest_ptrs[i*4 +: 4];  // R16
      end
    end
  end

endmodule // caf_route_select

`default_nettype wire

// file: tb/caf_accept_filter_asserts.sv
// port-level checker for the acceptance filter
`timescale 1ns/1ps
`default_nettype none
module caf_accept_filter_asserts (
  // clock, reset, apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  // message path
  input wire logic        rx_valid,
  input wire logic        acc_valid,
  input wire logic        acc_to_fifo,
  input wire logic [3:0]  acc_dest,
  input wire logic [3:0]  acc_filter,
  input wire logic        acc_overflow,
  input wire logic        rej_valid,
  // buffer flags
  input wire logic [14:0] rx_buffer_full_flags,
  input wire logic [14:0] rx_buffer_overflow_flags
);
  logic [14:0] full_d;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // flags one cycle back: overflow is judged on the state before the store
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      full_d <= 15'h0000;
    else
      full_d <= rx_buffer_full_flags;
  property p_fifo_code;
    acc_valid |-> acc_to_fifo == (acc_dest == 4'hf);
  endproperty
  a_fifo_code: assert property (p_fifo_code) else $error("fifo flag vs pointer");
  property p_one_answer;
    rx_valid |=> acc_valid != rej_valid;
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("no single answer");
  property p_quiet;
    !rx_valid |=> !acc_valid && !rej_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer without offer");
  property p_full_set;
    acc_valid && !acc_to_fifo |-> rx_buffer_full_flags[acc_dest];
  endproperty
  a_full_set: assert property (p_full_set) else $error("full flag not set");
  property p_ovf_code;
    acc_valid |-> acc_overflow == (!acc_to_fifo && full_d[acc_dest]) && !(acc_overflow && !rx_buffer_overflow_flags[acc_dest]);
  endproperty
  a_ovf_code: assert property (p_ovf_code) else $error("overflow wrong");
  property p_full_src;
    (rx_buffer_full_flags & ~$past(rx_buffer_full_flags)) != 15'h0000 |-> acc_valid && !acc_to_fifo;
  endproperty
  a_full_src: assert property (p_full_src) else $error("full flag rose alone");
  property p_ovf_src;
    (rx_buffer_overflow_flags & ~$past(rx_buffer_overflow_flags)) != 15'h0000 |-> acc_overflow;
  endproperty
  a_ovf_src: assert property (p_ovf_src) else $error("overflow flag rose alone");
  property p_clr_src;
    (~rx_buffer_full_flags & $past(rx_buffer_full_flags)) != 15'h0000 |-> $past(psel && penable && pwrite);
  endproperty
  a_clr_src: assert property (p_clr_src) else $error("full flag fell alone");
  property p_hold;
    !acc_valid |-> $stable(acc_dest) && $stable(acc_filter);
  endproperty
  a_hold: assert property (p_hold) else $error("route moved");
  c_fifo: cover property (acc_valid && acc_to_fifo);
  c_ovf: cover property (acc_overflow);
  c_rej: cover property (rej_valid);
endmodule // caf_accept_filter_asserts
bind caf_accept_filter caf_accept_filter_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .rx_valid, .acc_valid, .acc_to_fifo, .acc_dest, .acc_filter, .acc_overflow, .rej_valid,
  .rx_buffer_full_flags, .rx_buffer_overflow_flags);
`default_nettype wire

// file: tb/caf_rx_engine_model.sv
// protocol engine stand-in offering received identifiers
`timescale 1ns/1ps
`default_nettype none
module caf_rx_engine_model (
  // clock
  input  wire logic   pclk,
  // identifier offer
  output logic        rx_valid,
  output logic        rx_ext,
  output logic [10:0] rx_std_id,
  output logic [17:0] rx_ext_id
);
  initial
  begin
    rx_valid = 1'h0;
    rx_ext = 1'h0;
    rx_std_id = 11'h000;
    rx_ext_id = 18'h0_0000;
  end
  ////////////////////////////////////////
  // one-cycle offer; fields inverted after so a stale id cannot match by luck
  task automatic send(input logic ext, input logic [10:0] std_id_bits, input logic [17:0] ext_id_bits);
    begin
      @(posedge pclk);
      rx_valid <= 1'h1;
      rx_ext <= ext;
      rx_std_id <= std_id_bits;
      rx_ext_id <= ext_id_bits;
      @(posedge pclk);
      rx_valid <= 1'h0;
      rx_ext <= ~ext;
      rx_std_id <= ~std_id_bits;
      rx_ext_id <= ~ext_id_bits;
    end
  endtask
endmodule // caf_rx_engine_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench: apb registers, routing, flags, interrupt
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pready, pslverr, acc_valid, acc_to_fifo, acc_overflow, rej_valid, irq, rx_valid, rx_ext;
  logic [31:0] prdata, rd_v;
  logic [3:0]  acc_dest, acc_filter;
  logic [10:0] rx_std_id;
  logic [17:0] rx_ext_id;
  logic [14:0] rx_buffer_full_flags, rx_buffer_overflow_flags;
  logic        rd_e;
  int          fails = 0;
  int          n_tests = 0;
  always #5 pclk = ~pclk;
  caf_accept_filter dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .rx_valid, .rx_ext, .rx_std_id, .rx_ext_id, .acc_valid, .acc_to_fifo,
    .acc_dest, .acc_filter, .acc_overflow, .rej_valid, .rx_buffer_full_flags,
    .rx_buffer_overflow_flags, .irq);
  caf_rx_engine_model u_eng (.pclk, .rx_valid, .rx_ext, .rx_std_id, .rx_ext_id);
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_tests++;
      if (seen !== exp)
      begin
        fails++;
        $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  // one apb transfer; waits on pready rather than assuming zero wait states
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // no fixed wait count; only the watchdog ends a stalled transfer
      do
        @(posedge pclk);
      while (pready !== 1'h1);
      rd_v = prdata;
      rd_e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    begin
      xfer(1'h0, a, 32'h0000_0000);
      chk(rd_v, exp);
    end
  endtask
  // offer one id and check the answer one cycle later
  task automatic msg(input logic ext, input logic [10:0] std_id_bits, input logic [17:0] ext_id_bits,
                     input logic acc, input logic [3:0] f, input logic [3:0] dst);
    begin
      u_eng.send(ext, std_id_bits, ext_id_bits);
      #1;
      chk({acc_valid, rej_valid}, {acc, ~acc});
      if (acc)
        chk({acc_filter, acc_dest, acc_to_fifo}, {f, dst, dst == 4'hf});
    end
  endtask
  task automatic test_done;
    begin
      $display("compares %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // hang guard; the sequence needs well under 2000 cycles
  initial
  begin
    #100000;
    fails++;
    test_done;
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    rd(8'h00, 32'h0000_ffff);
    rd(8'h10, 32'h0000_0000);
    xfer(1'h0, 8'hcc, 32'h0000_0000);
    chk(rd_e, 32'h0000_0001);
    wr(8'h40, 32'h0000_ffff);
    rd(8'h40, 32'h0000_ffeb);
    wr(8'hc0, 32'h0000_ffff);
    rd(8'hc0, 32'h0000_ffeb);
    // filter 0 now wants extended frames only, so filter 1 takes the standard one
    msg(1'h0, 11'h000, 18'h0_0000, 1'h1, 4'h1, 4'h0);
    chk(acc_overflow, 32'h0000_0000);
    msg(1'h1, 11'h7ff, 18'h3_0000, 1'h1, 4'h0, 4'h0);
    chk(acc_overflow, 32'h0000_0001);
    msg(1'h1, 11'h7ff, 18'h1_0000, 1'h0, 4'h0, 4'h0);
    msg(1'h1, 11'h7ff, 18'h3_1234, 1'h1, 4'h0, 4'h0);
    rd(8'h20, 32'h0000_0001);
    rd(8'h24, 32'h0000_0001);
    wr(8'h20, 32'h0000_0000);
    wr(8'h24, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    rd(8'h24, 32'h0000_0000);
    wr(8'hd0, 32'h0000_ffff);
    msg(1'h1, 11'h7ff, 18'h3_1234, 1'h0, 4'h0, 4'h0);
    wr(8'h80, 32'h0000_1234);
    msg(1'h1, 11'h7ff, 18'h3_1234, 1'h1, 4'h0, 4'h0);
    // only filters 14 and 15; 14 starts on the reserved mask source
    wr(8'h10, 32'h0000_fe00);
    wr(8'h00, 32'h0000_c000);
    wr(8'h18, 32'h0000_7000);
    msg(1'h0, 11'h555, 18'h0_0000, 1'h1, 4'hf, 4'hf);
    wr(8'h18, 32'h0000_6000);
    msg(1'h0, 11'h555, 18'h0_0000, 1'h1, 4'he, 4'he);
    wr(8'hc8, 32'h0000_ffe3);
    wr(8'h78, 32'h0000_2aa1);
    msg(1'h0, 11'h155, 18'h0_0000, 1'h1, 4'he, 4'he);
    msg(1'h1, 11'h155, 18'h1_0000, 1'h1, 4'he, 4'he);
    msg(1'h1, 11'h155, 18'h2_0000, 1'h1, 4'hf, 4'hf);
    msg(1'h0, 11'h154, 18'h0_0000, 1'h1, 4'hf, 4'hf);
    // lowest standard id bit made a don't-care in mask 2, then compared again
    wr(8'hc8, 32'h0000_ffc3);
    msg(1'h0, 11'h154, 18'h0_0000, 1'h1, 4'he, 4'he);
    wr(8'hc8, 32'h0000_ffe3);
    wr(8'h00, 32'h0000_4000);
    msg(1'h0, 11'h154, 18'h0_0000, 1'h0, 4'h0, 4'h0);
    // interrupt: read clears, mask passes only the no-hit event
    rd(8'h28, 32'h0000_000f);
    rd(8'h28, 32'h0000_0000);
    wr(8'h2c, 32'h0000_0008);
    msg(1'h0, 11'h154, 18'h0_0000, 1'h0, 4'h0, 4'h0);
    chk(irq, 32'h0000_0001);
    msg(1'h0, 11'h155, 18'h0_0000, 1'h1, 4'he, 4'he);
    rd(8'h28, 32'h0000_000d);
    #1;
    chk(irq, 32'h0000_0000);
    msg(1'h0, 11'h155, 18'h0_0000, 1'h1, 4'he, 4'he);
    chk(irq, 32'h0000_0000);
    rd(8'h20, 32'h0000_4001);
    rd(8'h24, 32'h0000_4000);
    test_done;
  end
endmodule // testbench
`default_nettype wire
